// File: rtl/dma_channel_zero_control.v
// Control of DMA channel pair zero: registers, triggers, pointer steps
`timescale 1ns/1ns
module dma_channel_zero_control (
	input wire clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [31:0] reg_rdata,
	input wire [3:0] timer_match,
	input wire sci_tx_empty,
	input wire sci_rx_full,
	input wire external_transfer_request_pin_n,
	input wire count_end_a,
	input wire count_end_b,
	output reg req_a,
	output reg req_b,
	output reg req_full,
	output reg [23:0] mem_addr_a,
	output reg [23:0] mem_addr_b,
	output reg [7:0] io_addr_a,
	output reg [7:0] io_addr_b,
	output reg word_a,
	output reg word_b,
	output wire full_mode,
	output wire block_mode,
	output wire irq
);
`include "dma_zero_defs.vh"

	// Software visible state
	reg [23:0] ptr_a;
	reg [23:0] ptr_b;
	reg [23:0] start_a;
	reg [23:0] start_b;
	reg [7:0] io_a;
	reg [7:0] io_b;
	reg [7:0] ctrl_a;
	reg [7:0] ctrl_b;
	reg [1:0] status;
	reg [1:0] mask;
	reg [1:0] next_status;
	reg [31:0] next_rdata;

	// Enable history for the end event
	reg en_prev_a;
	reg en_prev_b;

	// Request pin synchroniser and filtered level
	reg external_transfer_request_pin_s1;
	reg external_transfer_request_pin_s2;
	reg external_transfer_request_pin_s3;
	reg external_transfer_request_pin_lvl;

	wire external_transfer_request_pin_fall;
	wire external_transfer_request_pin_low;
	wire trig_a;
	wire trig_b;
	wire [23:0] next_ptr_a;
	wire [23:0] next_ptr_b;

	// Write strobes per register and the status read strobe
	wire wr_ptr_a;
	wire wr_ptr_b;
	wire wr_io_a;
	wire wr_io_b;
	wire wr_ctrl_a;
	wire wr_ctrl_b;
	wire wr_mask;
	wire rd_status;

	assign wr_ptr_a = reg_write & (reg_addr == `OFS_SRC_PTR);
	assign wr_ptr_b = reg_write & (reg_addr == `OFS_MEM_B);
	assign wr_io_a = reg_write & (reg_addr == `OFS_IO_A);
	assign wr_io_b = reg_write & (reg_addr == `OFS_IO_B);
	assign wr_ctrl_a = reg_write & (reg_addr == `OFS_CTRL_A);
	assign wr_ctrl_b = reg_write & (reg_addr == `OFS_CTRL_B);
	assign wr_mask = reg_write & (reg_addr == `OFS_MASK);
	assign rd_status = reg_read & (reg_addr == `OFS_STATUS);

	// Codes 6 and 7 on sub-channel A switch the pair to full mode
	assign full_mode = ctrl_a[`BIT_SEL_HI] & ctrl_a[`BIT_SEL_MID];
	// Lowest A select bit picks block transfer in full mode
	assign block_mode = full_mode & ctrl_a[`BIT_SEL_LO];

	// Short mode operating modes
	wire repeat_a;
	wire repeat_b;
	wire idle_a;
	wire idle_b;

	// Repeat off gives I/O mode regardless of interrupt enable
	assign repeat_a = ctrl_a[`BIT_REPEAT] & ~ctrl_a[`BIT_IE];
	assign repeat_b = ctrl_b[`BIT_REPEAT] & ~ctrl_b[`BIT_IE];
	assign idle_a = ctrl_a[`BIT_REPEAT] & ctrl_a[`BIT_IE];
	assign idle_b = ctrl_b[`BIT_REPEAT] & ctrl_b[`BIT_IE];

	// Transfer launch conditions
	wire fire_a;
	wire fire_b;
	wire fire_full;

	// Nothing launches while the enable bit is clear
	assign fire_a = ~full_mode & ctrl_a[`BIT_ENABLE] & trig_a;
	assign fire_b = ~full_mode & ctrl_b[`BIT_ENABLE] & trig_b;
	assign fire_full = full_mode & ctrl_a[`BIT_ENABLE] &
		ctrl_b[`BIT_ENABLE] & trig_b;

	// Pointer step controls
	wire step_en_a;
	wire step_en_b;
	wire size_b;

	// Short mode always steps; full mode steps on the enable bits
	assign step_en_a = full_mode ? ctrl_a[`BIT_STEP_EN] : 1'b1;
	assign step_en_b = full_mode ? ctrl_b[`BIT_STEP_EN] : 1'b1;
	assign size_b = full_mode ? ctrl_a[`BIT_SIZE] : ctrl_b[`BIT_SIZE];

	// Source side or sub-channel A pointer step
	address_stepper step_a (
		.addr(ptr_a),
		.step_en(step_en_a),
		.down(ctrl_a[`BIT_DIR]),
		.word(ctrl_a[`BIT_SIZE]),
		.next_addr(next_ptr_a)
	);

	// Destination side or sub-channel B pointer step
	address_stepper step_b (
		.addr(ptr_b),
		.step_en(step_en_b),
		.down(ctrl_b[`BIT_DIR]),
		.word(size_b),
		.next_addr(next_ptr_b)
	);

	// Sub-channel A trigger, short mode only, no request pin
	activation_select sel_a (
		.code(ctrl_a[`BIT_SEL_HI:`BIT_SEL_LO]),
		.full_mode(1'b0),
		.block_mode(1'b0),
		.allow_external_transfer_request_pin(1'b0),
		.timer_match(timer_match),
		.sci_tx_empty(sci_tx_empty),
		.sci_rx_full(sci_rx_full),
		.external_transfer_request_pin_fall(external_transfer_request_pin_fall),
		.external_transfer_request_pin_low(external_transfer_request_pin_low),
		.trigger(trig_a)
	);

	// Sub-channel B trigger, also the pair trigger in full mode
	activation_select sel_b (
		.code(ctrl_b[`BIT_SEL_HI:`BIT_SEL_LO]),
		.full_mode(full_mode),
		.block_mode(block_mode),
		.allow_external_transfer_request_pin(1'b1),
		.timer_match(timer_match),
		.sci_tx_empty(sci_tx_empty),
		.sci_rx_full(sci_rx_full),
		.external_transfer_request_pin_fall(external_transfer_request_pin_fall),
		.external_transfer_request_pin_low(external_transfer_request_pin_low),
		.trigger(trig_b)
	);

	// Request pin: three stages, change accepted when last two agree
	always @(posedge clk) begin
		if (rst) begin
			external_transfer_request_pin_s1 <= 1'b1;
			external_transfer_request_pin_s2 <= 1'b1;
			external_transfer_request_pin_s3 <= 1'b1;
			external_transfer_request_pin_lvl <= 1'b1;
		end else begin
			external_transfer_request_pin_s1 <= external_transfer_request_pin_n;
			external_transfer_request_pin_s2 <= external_transfer_request_pin_s1;
			external_transfer_request_pin_s3 <= external_transfer_request_pin_s2;
			if (external_transfer_request_pin_s2 == external_transfer_request_pin_s3) begin
				external_transfer_request_pin_lvl <= external_transfer_request_pin_s3;
			end
		end
	end

	// Falling edge at the moment the filtered level drops
	assign external_transfer_request_pin_fall = (external_transfer_request_pin_s2 == external_transfer_request_pin_s3) & ~external_transfer_request_pin_s3 & external_transfer_request_pin_lvl;
	assign external_transfer_request_pin_low = ~external_transfer_request_pin_lvl;

	// Pointer A: write wins, then repeat reload, then step
	always @(posedge clk) begin
		if (rst) begin
			ptr_a <= `PTR_RESET;
			start_a <= `PTR_RESET;
		end else if (wr_ptr_a) begin
			ptr_a <= reg_wdata[23:0];
			start_a <= reg_wdata[23:0];
		end else if (~full_mode & repeat_a & count_end_a) begin
			ptr_a <= start_a;
		end else if (fire_a | fire_full) begin
			ptr_a <= next_ptr_a;
		end
	end

	// Pointer B: write wins, then repeat reload, then step
	always @(posedge clk) begin
		if (rst) begin
			ptr_b <= `PTR_RESET;
			start_b <= `PTR_RESET;
		end else if (wr_ptr_b) begin
			ptr_b <= reg_wdata[23:0];
			start_b <= reg_wdata[23:0];
		end else if (~full_mode & repeat_b & count_end_b) begin
			ptr_b <= start_b;
		end else if (fire_b | fire_full) begin
			ptr_b <= next_ptr_b;
		end
	end

	// I/O address registers
	always @(posedge clk) begin
		if (rst) begin
			io_a <= `IO_RESET;
			io_b <= `IO_RESET;
		end else begin
			if (wr_io_a) begin
				io_a <= reg_wdata[7:0];
			end
			if (wr_io_b) begin
				io_b <= reg_wdata[7:0];
			end
		end
	end

	// Control A: count end drops enable except in short repeat mode
	always @(posedge clk) begin
		if (rst) begin
			ctrl_a <= `CTRL_RESET;
		end else if (wr_ctrl_a) begin
			ctrl_a <= reg_wdata[7:0];
		end else if (count_end_a & (full_mode | ~repeat_a)) begin
			ctrl_a[`BIT_ENABLE] <= 1'b0;
		end
	end

	// Control B: master enable in full mode is left to software
	always @(posedge clk) begin
		if (rst) begin
			ctrl_b <= `CTRL_RESET;
		end else if (wr_ctrl_b) begin
			ctrl_b <= reg_wdata[7:0];
		end else if (count_end_b & ~full_mode & ~repeat_b) begin
			ctrl_b[`BIT_ENABLE] <= 1'b0;
		end
	end

	// End events: enable fell while end interrupt is enabled; none for B in full mode
	wire end_a;
	wire end_b;

	assign end_a = en_prev_a & ~ctrl_a[`BIT_ENABLE] &
		ctrl_a[`BIT_IE];
	assign end_b = en_prev_b & ~ctrl_b[`BIT_ENABLE] &
		ctrl_b[`BIT_IE] & ~full_mode;

	// Enable history
	always @(posedge clk) begin
		if (rst) begin
			en_prev_a <= 1'b0;
			en_prev_b <= 1'b0;
		end else begin
			en_prev_a <= ctrl_a[`BIT_ENABLE];
			en_prev_b <= ctrl_b[`BIT_ENABLE];
		end
	end

	// Sticky status: read clears, a new event wins over the clear
	always @* begin
		next_status = rd_status ? 2'h0 : status;
		next_status[`STAT_END_A] = next_status[`STAT_END_A] | end_a;
		next_status[`STAT_END_B] = next_status[`STAT_END_B] | end_b;
	end

	// Status and mask registers
	always @(posedge clk) begin
		if (rst) begin
			status <= 2'h0;
			mask <= 2'h0;
		end else begin
			status <= next_status;
			if (wr_mask) begin
				mask <= reg_wdata[1:0];
			end
		end
	end

	// Level interrupt while any unmasked status bit is set
	assign irq = |(status & mask);

	// Read multiplexer; upper pointer byte reads as ones
	always @* begin
		next_rdata = 32'h00000000;
		case (reg_addr)
			`OFS_SRC_PTR: begin
				next_rdata = {`PTR_UPPER, ptr_a};
			end
			`OFS_MEM_B: begin
				next_rdata = {`PTR_UPPER, ptr_b};
			end
			`OFS_IO_A: begin
				next_rdata = {24'h000000, io_a};
			end
			`OFS_IO_B: begin
				next_rdata = {24'h000000, io_b};
			end
			`OFS_CTRL_A: begin
				next_rdata = {24'h000000, ctrl_a};
			end
			`OFS_CTRL_B: begin
				next_rdata = {24'h000000, ctrl_b};
			end
			`OFS_STATUS: begin
				next_rdata = {30'h00000000, status};
			end
			`OFS_MASK: begin
				next_rdata = {30'h00000000, mask};
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Transfer request pulses
	always @(posedge clk) begin
		if (rst) begin
			req_a <= 1'b0;
			req_b <= 1'b0;
			req_full <= 1'b0;
		end else begin
			req_a <= fire_a;
			req_b <= fire_b;
			req_full <= fire_full;
		end
	end

	// Addresses and size handed to the bus cycle logic
	always @(posedge clk) begin
		if (rst) begin
			mem_addr_a <= `PTR_RESET;
			mem_addr_b <= `PTR_RESET;
			io_addr_a <= `IO_RESET;
			io_addr_b <= `IO_RESET;
			word_a <= 1'b0;
			word_b <= 1'b0;
		end else begin
			if (fire_a | fire_full) begin
				mem_addr_a <= ptr_a;
				word_a <= ctrl_a[`BIT_SIZE];
			end
			if (fire_b | fire_full) begin
				mem_addr_b <= ptr_b;
				word_b <= size_b;
			end
			if (fire_a) begin
				io_addr_a <= io_a;
			end
			if (fire_b) begin
				io_addr_b <= io_b;
			end
		end
	end

endmodule

// File: rtl/dma_zero_defs.vh
// Offsets, field positions, codes and reset values of the channel pair
`ifndef DMA_ZERO_DEFS_VH
`define DMA_ZERO_DEFS_VH

`define OFS_SRC_PTR 8'h20
`define OFS_IO_A 8'h26
`define OFS_MEM_B 8'h28
`define OFS_IO_B 8'h2E
`define OFS_CTRL_A 8'h40
`define OFS_CTRL_B 8'h41
`define OFS_STATUS 8'h44
`define OFS_MASK 8'h45

`define BIT_ENABLE 7
`define BIT_SIZE 6
`define BIT_DIR 5
`define BIT_REPEAT 4
`define BIT_STEP_EN 4
`define BIT_IE 3
`define BIT_SEL_HI 2
`define BIT_SEL_MID 1
`define BIT_SEL_LO 0

`define STAT_END_A 0
`define STAT_END_B 1

`define CTRL_RESET 8'h00
`define PTR_RESET 24'h000000
`define IO_RESET 8'h00
`define PTR_UPPER 8'hFF
`define STEP_BYTE 24'h000001
`define STEP_WORD 24'h000002

`define CODE_TIMER3 3'h3
`define CODE_SCI_TX 3'h4
`define CODE_SCI_RX 3'h5
`define CODE_EXTERNAL_TRANSFER_REQUEST_PIN_FALL 3'h6
`define CODE_EXTERNAL_TRANSFER_REQUEST_PIN_LOW 3'h7
`define CODE_AUTO_BURST 3'h0
`define CODE_AUTO_STEAL 3'h2

`endif

// File: rtl/address_stepper.v
// Next memory pointer after one transfer: hold, up or down by size
`timescale 1ns/1ns
module address_stepper (
	input wire [23:0] addr,
	input wire step_en,
	input wire down,
	input wire word,
	output wire [23:0] next_addr
);
`include "dma_zero_defs.vh"

	wire [23:0] delta;

	// Byte steps by one, word by two
	assign delta = word ? `STEP_WORD : `STEP_BYTE;

	// Held, decremented or incremented
	assign next_addr = !step_en ? addr :
		(down ? addr - delta : addr + delta);

endmodule

// File: rtl/activation_select.v
// Decodes a three-bit select code into one transfer trigger
`timescale 1ns/1ns
module activation_select (
	input wire [2:0] code,
	input wire full_mode,
	input wire block_mode,
	input wire allow_external_transfer_request_pin,
	input wire [3:0] timer_match,
	input wire sci_tx_empty,
	input wire sci_rx_full,
	input wire external_transfer_request_pin_fall,
	input wire external_transfer_request_pin_low,
	output reg trigger
);
`include "dma_zero_defs.vh"

	// Source selection per address mode
	always @* begin
		trigger = 1'b0;
		if (!full_mode) begin
			case (code)
				3'h0, 3'h1, 3'h2, `CODE_TIMER3: begin
					trigger = timer_match[code[1:0]];
				end
				`CODE_SCI_TX: begin
					trigger = sci_tx_empty;
				end
				`CODE_SCI_RX: begin
					trigger = sci_rx_full;
				end
				`CODE_EXTERNAL_TRANSFER_REQUEST_PIN_FALL: begin
					trigger = allow_external_transfer_request_pin & external_transfer_request_pin_fall;
				end
				`CODE_EXTERNAL_TRANSFER_REQUEST_PIN_LOW: begin
					trigger = allow_external_transfer_request_pin & external_transfer_request_pin_low;
				end
				default: begin
					trigger = 1'b0;
				end
			endcase
		end else if (block_mode) begin
			case (code)
				3'h0, 3'h1, 3'h2, `CODE_TIMER3: begin
					trigger = timer_match[code[1:0]];
				end
				`CODE_EXTERNAL_TRANSFER_REQUEST_PIN_FALL: begin
					trigger = external_transfer_request_pin_fall;
				end
				default: begin
					trigger = 1'b0;
				end
			endcase
		end else begin
			case (code)
				`CODE_AUTO_BURST, `CODE_AUTO_STEAL: begin
					trigger = 1'b1;
				end
				`CODE_EXTERNAL_TRANSFER_REQUEST_PIN_FALL: begin
					trigger = external_transfer_request_pin_fall;
				end
				`CODE_EXTERNAL_TRANSFER_REQUEST_PIN_LOW: begin
					trigger = external_transfer_request_pin_low;
				end
				default: begin
					trigger = 1'b0;
				end
			endcase
		end
	end

endmodule

// File: verification/dma_event_source.sv
// Far-side model: timers, serial channel, request pin, transfer counters
`timescale 1ns/1ns
module dma_event_source (
	input wire clk,
	output reg [3:0] timer_match,
	output reg sci_tx_empty,
	output reg sci_rx_full,
	output reg external_transfer_request_pin_n,
	output reg count_end_a,
	output reg count_end_b
);
	reg [7:0] ev = 8'h00;
	initial external_transfer_request_pin_n = 1'b1;
	// One bit per event source, in select-code order
	always_comb begin
		{count_end_b, count_end_a, sci_rx_full, sci_tx_empty, timer_match} = ev;
	end
	// Hold one source high for n cycles, then drop it
	task fire(input int idx, input int n);
		@(posedge clk);
		ev <= 8'h01 << idx;
		repeat (n) @(posedge clk);
		ev <= 8'h00;
	endtask
	// Drive the request pin level
	task pin(input logic lv);
		@(posedge clk);
		external_transfer_request_pin_n <= lv;
	endtask
endmodule

// File: verification/dma_channel_zero_control_asserts.sv
// Port checker of the channel pair zero control
`timescale 1ns/1ns
`include "dma_zero_defs.vh"
module dma_zero_checker (
	input wire clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [31:0] reg_rdata,
	input wire req_a,
	input wire req_b,
	input wire req_full,
	input wire [23:0] mem_addr_a,
	input wire [23:0] mem_addr_b,
	input wire [7:0] io_addr_b,
	input wire full_mode,
	input wire irq
);
	reg [6:4] sa;
	reg [6:4] sb;
	reg [7:0] iob;
	wire [23:0] st_a = sa[6] ? `STEP_WORD : `STEP_BYTE;
	wire [23:0] st_b = sb[6] ? `STEP_WORD : `STEP_BYTE;
	// Shadows of size, direction and I/O address as written
	always @(posedge clk) begin
		if (rst) begin
			sa <= 3'h0;
			sb <= 3'h0;
			iob <= 8'h00;
		end else if (reg_write) begin
			if (reg_addr == `OFS_CTRL_A)
				sa <= reg_wdata[6:4];
			if (reg_addr == `OFS_CTRL_B)
				sb <= reg_wdata[6:4];
			if (reg_addr == `OFS_IO_B)
				iob <= reg_wdata[7:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	full_select_a: assert property (
		reg_write && reg_addr == `OFS_CTRL_A |=> full_mode ==
		($past(reg_wdata[2]) && $past(reg_wdata[1]))) else $error("full mode");
	no_short_req_a: assert property (
		full_mode && $past(full_mode) |-> !req_a && !req_b)
		else $error("short request in full mode");
	off_stops_a: assert property (
		reg_write && reg_addr == `OFS_CTRL_B && !reg_wdata[7] |=> ##1 !req_b)
		else $error("request while disabled");
	upper_ones_a: assert property (
		$past(reg_read) && $past(reg_addr) == `OFS_MEM_B |->
		reg_rdata[31:24] == `PTR_UPPER) else $error("pointer upper byte");
	rd_idle_a: assert property (
		!$past(reg_read) |-> reg_rdata == 32'h00000000)
		else $error("read data outside answer cycle");
	b_step_a: assert property (
		req_b && $past(req_b) && !$past(reg_write) && !$past(reg_write, 2)
		|-> mem_addr_b == (sb[5] ? $past(mem_addr_b) - st_b :
		$past(mem_addr_b) + st_b)) else $error("short pointer step");
	a_full_step_a: assert property (
		req_full && $past(req_full) && !$past(reg_write) |-> mem_addr_a ==
		(!sa[4] ? $past(mem_addr_a) : sa[5] ? $past(mem_addr_a) - st_a :
		$past(mem_addr_a) + st_a)) else $error("source pointer step");
	io_b_a: assert property (
		req_b && !$past(reg_write) |-> io_addr_b == iob)
		else $error("I/O address");
	irq_mask_a: assert property (
		reg_write && reg_addr == `OFS_MASK && reg_wdata[1:0] == 2'h0 |=> !irq)
		else $error("masked interrupt");
	cover property (req_full && $past(req_full));
	cover property (req_b && $past(req_b));
	cover property (irq);
endmodule
bind dma_channel_zero_control dma_zero_checker i_chk (.*);

// File: verification/tb_dma_channel_zero_control.sv
// Self-checking bench of the channel pair zero control
`timescale 1ns/1ns
`include "dma_zero_defs.vh"
module tb_dma_channel_zero_control;
	logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	wire [31:0] reg_rdata;
	wire [3:0] timer_match;
	wire sci_tx_empty, sci_rx_full, external_transfer_request_pin_n, count_end_a, count_end_b;
	wire req_a, req_b, req_full, word_a, word_b, full_mode, block_mode, irq;
	wire [23:0] mem_addr_a, mem_addr_b;
	wire [7:0] io_addr_a, io_addr_b;
	logic [34:0] exp_ev[$], g;
	logic [31:0] exp_rd[$];
	int n_mismatch = 0, compares = 0, n_free = 0, cyc = 0, c, k;
	logic rd_pend = 1'b0, free_b = 1'b0;
	logic [23:0] p;
	logic [7:0] io;
	logic [1:0] wd;
	dma_channel_zero_control i_dut (.*);
	dma_event_source i_src (.*);
	always #20 clk = ~clk;
	task chk(input logic [34:0] got, input logic [34:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Read answers against the expected register value
	task chk_rd(input logic [31:0] got, input logic [31:0] exp);
		chk({3'h0, got}, {3'h0, exp});
	endtask
	// Issued transfers against the noted kind, size and addresses
	task chk_ev(input logic [34:0] got, input logic [34:0] exp);
		chk(got, exp);
	endtask
	task wrap_up;
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
	endtask
	task note(input logic [1:0] kd, input w, input [7:0] i, input [23:0] a);
		exp_ev.push_back({kd, w, i, a});
	endtask
	task done(input string s);
		repeat (6) @(posedge clk);
		chk(exp_ev.size(), 0);
		$display("test %s done", s);
	endtask
	function automatic [23:0] nx(input [23:0] a, input w, input dn);
		nx = dn ? a - (w ? `STEP_WORD : `STEP_BYTE)
			: a + (w ? `STEP_WORD : `STEP_BYTE);
	endfunction
	// Watcher: read answers and issued transfers against the notes
	always @(posedge clk) begin
		if (rd_pend)
			chk_rd(reg_rdata, exp_rd.pop_front());
		rd_pend <= reg_read;
		g = req_full ? {3'h6, 8'h00, mem_addr_a} : req_a ?
			{2'h1, word_a, io_addr_a, mem_addr_a} :
			{2'h2, word_b, io_addr_b, mem_addr_b};
		if (!rst && (req_a || req_b || req_full)) begin
			if (free_b && req_b)
				n_free++;
			else
				chk_ev(g, exp_ev.size() ? exp_ev.pop_front() : 35'h0);
		end
		if (++cyc == 20000) begin
			n_mismatch++;
			wrap_up;
		end
	end
	initial begin
		p = 24'($urandom(72));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`OFS_CTRL_A, 0);
		rd(`OFS_CTRL_B, 0);
		rd(`OFS_STATUS, 0);
		rd(`OFS_MASK, 0);
		rd(`OFS_MEM_B, 32'hFF000000);
		wr(`OFS_MEM_B, 32'h12345678);
		rd(`OFS_MEM_B, 32'hFF345678);
		rd(8'h10, 0);
		done("registers");
		// Short codes 0 to 5 on both sub-channels, off first then on
		for (c = 0; c < 2; c++)
			for (k = 0; k < 6; k++) begin
				p = 24'($urandom);
				io = 8'($urandom);
				wd = 2'($urandom);
				wr(c ? `OFS_MEM_B : `OFS_SRC_PTR, {8'h00, p});
				wr(c ? `OFS_IO_B : `OFS_IO_A, {24'h0, io});
				wr(`OFS_CTRL_A + c, {24'h0, 1'b0, wd, 2'h0, 3'(k)});
				i_src.fire(k, 1);
				wr(`OFS_CTRL_A + c, {24'h0, 1'b1, wd, 2'h0, 3'(k)});
				note(c ? 2'h2 : 2'h1, wd[1], io, p);
				note(c ? 2'h2 : 2'h1, wd[1], io, nx(p, wd[1], wd[0]));
				i_src.fire(k, 2);
				wr(`OFS_CTRL_A + c, 0);
				done("short codes");
			end
		wr(`OFS_MEM_B, 0);
		wr(`OFS_CTRL_B, 32'h86);
		note(2'h2, 1'b0, io, 0);
		i_src.pin(0);
		repeat (10) @(posedge clk);
		i_src.pin(1);
		done("pin edge");
		free_b = 1'b1;
		wr(`OFS_CTRL_B, 32'h87);
		i_src.pin(0);
		repeat (10) @(posedge clk);
		wr(`OFS_CTRL_B, 0);
		i_src.pin(1);
		done("pin level");
		free_b = 1'b0;
		chk(n_free > 5, 1);
		wr(`OFS_MASK, 2);
		wr(`OFS_CTRL_B, 32'h98);
		i_src.fire(7, 1);
		done("idle end");
		chk({34'h0, irq}, 1);
		rd(`OFS_CTRL_B, 32'h18);
		rd(`OFS_STATUS, 2);
		done("status clear");
		chk({34'h0, irq}, 0);
		wr(`OFS_CTRL_B, 32'h80);
		i_src.fire(7, 1);
		rd(`OFS_CTRL_B, 0);
		rd(`OFS_STATUS, 0);
		wr(`OFS_MASK, 0);
		wr(`OFS_CTRL_B, 32'h88);
		wr(`OFS_CTRL_B, 32'h08);
		done("masked");
		chk({34'h0, irq}, 0);
		rd(`OFS_STATUS, 2);
		// Count end on sub-channel A drops enable and raises its status
		wr(`OFS_MASK, 1);
		wr(`OFS_CTRL_A, 32'h88);
		i_src.fire(6, 1);
		done("end a");
		chk({34'h0, irq}, 1);
		rd(`OFS_CTRL_A, 32'h08);
		rd(`OFS_STATUS, 1);
		wr(`OFS_MEM_B, {8'h00, p});
		wr(`OFS_CTRL_B, 32'h90);
		note(2'h2, 1'b0, io, p);
		i_src.fire(0, 1);
		i_src.fire(7, 1);
		note(2'h2, 1'b0, io, p);
		i_src.fire(0, 1);
		rd(`OFS_CTRL_B, 32'h90);
		wr(`OFS_CTRL_B, 0);
		done("repeat");
		// Block transfers for each step-enable and direction pair
		for (k = 0; k < 4; k++) begin
			p = 24'($urandom);
			wd = 2'($urandom);
			wr(`OFS_SRC_PTR, {8'h00, p});
			wr(`OFS_CTRL_B, 32'h81);
			wr(`OFS_CTRL_A, {24'h0, 1'b1, wd[1], 2'(k), 4'h7});
			note(2'h3, 1'b0, 8'h00, p);
			note(2'h3, 1'b0, 8'h00, k[0] ? nx(p, wd[1], k[1]) : p);
			i_src.fire(1, 2);
			chk({33'h0, full_mode, block_mode}, 3);
			wr(`OFS_CTRL_A, 0);
			wr(`OFS_CTRL_B, 0);
			done("full mode");
		end
		// Normal full mode: pin edge moves the pair, source held
		wr(`OFS_SRC_PTR, {8'h00, p});
		wr(`OFS_CTRL_B, 32'h86);
		wr(`OFS_CTRL_A, 32'h86);
		note(2'h3, 1'b0, 8'h00, p);
		i_src.pin(0);
		repeat (10) @(posedge clk);
		chk({33'h0, full_mode, block_mode}, 2);
		i_src.pin(1);
		wr(`OFS_CTRL_A, 0);
		wr(`OFS_CTRL_B, 0);
		done("normal mode");
		wrap_up;
	end
endmodule
